// ---- src/rfw_pkg.sv ----
// Package for the register file, its error-protection control and the watchpoints.
// Assumes a single core clock and an integer pipeline that issues all accesses.
package rfw_pkg;

   // Ancillary state register numbers.
   localparam logic [4:0] ASR_PROT_CTRL = 5'h10;
   localparam logic [4:0] ASR_WATCH_BASE = 5'h18;
   localparam int NUM_WATCH = 4;

   // Watch address register fields.
   localparam int WADDR_LSB = 2;
   localparam int WATCH_FETCH_BIT = 0;
   // Watch mask register fields.
   localparam int WMASK_LOAD_BIT = 1;
   localparam int WMASK_STORE_BIT = 0;

   // Protection control fields.
   localparam int CNT_LSB = 9;
   localparam int CNT_MSB = 11;
   localparam int TCB_LSB = 2;
   localparam int TCB_MSB = 8;
   localparam int TEST_BIT = 1;
   localparam int DISABLE_BIT = 0;

   // Reset values.
   localparam logic [31:0] WATCH_RESET = 32'h00000000;
   localparam logic [2:0] CNT_RESET = 3'h0;
   localparam logic [6:0] TCB_RESET = 7'h00;

   // Register window geometry.
   localparam int NWIN = 8;
   localparam int CB_W = 7;
   localparam logic [4:0] REG_LOCAL1 = 5'h11;
   localparam logic [4:0] REG_LOCAL2 = 5'h12;
   localparam logic [4:0] REG_IN_BASE = 5'h18;
   localparam logic [4:0] REG_LOCAL_BASE = 5'h10;
   localparam logic [4:0] REG_OUT_BASE = 5'h08;

   // One ancillary register access.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] num;
      logic [31:0] wdata;
   } rfw_asr_req_t;

   // One memory-side access to be checked by the watchpoints.
   typedef struct packed {
      logic fetch;
      logic load;
      logic store;
      logic [31:0] addr;
   } rfw_watch_req_t;

endpackage : rfw_pkg

// ---- src/rfw_watch_unit.sv ----
// One watchpoint: an address register and a mask register with compare logic.
// Assumes writes arrive already decoded for this watchpoint.
`timescale 1ns/1ps
module rfw_watch_unit
   import rfw_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic addr_we,
   input wire logic mask_we,
   input wire logic [31:0] wdata,
   input wire rfw_pkg::rfw_watch_req_t acc,
   output logic [31:0] addr_rd,
   output logic [31:0] mask_rd,
   output logic hit
);
   logic [31:2] waddr_q;
   logic fetch_en_q;
   logic [31:2] wmask_q;
   logic load_en_q;
   logic store_en_q;
   logic match;

   ////////////////////////////////////////////////////////////////////////
   // Address register; reserved bit 1 stays zero.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waddr_q <= WATCH_RESET[31:2];
         fetch_en_q <= 1'b0; // RULE_05
      end else if (addr_we) begin
         waddr_q <= wdata[31:WADDR_LSB]; // RULE_03
         fetch_en_q <= wdata[WATCH_FETCH_BIT];
      end
   end

   // Mask register with the two data access enables.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wmask_q <= WATCH_RESET[31:2];
         load_en_q <= 1'b0;
         store_en_q <= 1'b0;
      end else if (mask_we) begin
         wmask_q <= wdata[31:WADDR_LSB];
         load_en_q <= wdata[WMASK_LOAD_BIT];
         store_en_q <= wdata[WMASK_STORE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Only mask-enabled bits take part, so a zero mask watches every address.
   assign match = ~|((acc.addr[31:2] ^ waddr_q) & wmask_q); // RULE_04
   assign hit = match & ((acc.fetch & fetch_en_q) // RULE_05
                | (acc.load & load_en_q) // RULE_06
                | (acc.store & store_en_q)); // RULE_07 RULE_20
   assign addr_rd = {waddr_q, 1'b0, fetch_en_q}; // RULE_21
   assign mask_rd = {wmask_q, load_en_q, store_en_q};

endmodule : rfw_watch_unit

// ---- src/rfw_win_store.sv ----
// Flip-flop storage for the windowed working registers with stored checkbits.
// Assumes one write and two reads per cycle, indexed by physical slot.
`timescale 1ns/1ps
module rfw_win_store
   import rfw_pkg::*;
#(
   parameter int DEPTH = 136,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [38:0] wdata,
   input wire logic [AW-1:0] raddr_a,
   input wire logic [AW-1:0] raddr_b,
   output logic [38:0] rdata_a,
   output logic [38:0] rdata_b
);
   // No reset: contents are undefined until software writes them.
   logic [38:0] mem [DEPTH];

   ////////////////////////////////////////////////////////////////////////
   // Write port.
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Registered read ports keep the data outputs on flip-flops.
   always_ff @(posedge clk) begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
   end

endmodule : rfw_win_store

// ---- src/rfw_regfile.sv ----
// Windowed working register file with error protection, its control register
// and four watchpoints; the control register and watchpoints are reached by ancillary register reads and writes.
// Assumes the integer pipeline supplies window pointer, accesses and trap events.
`timescale 1ns/1ps

// Notes on behaviour
// [RULE_01] Four watch address registers at 24,26,28,30.
// [RULE_02] Watch mask registers at 25,27,29,31.
// [RULE_03] Address bits 31:2 hold watched address.
// [RULE_04] Mask bit one enables comparing that bit.
// [RULE_05] Address bit 0 enables fetch hits, resets zero.
// [RULE_06] Mask bit 1 enables load hits.
// [RULE_07] Mask bit 0 enables store hits.
// [RULE_08] Protection control sits at register 16.
// [RULE_09] Correction counter bits 11:9 saturates at seven.
// [RULE_10] Test mode XORs checkbits with bits 8:2.
// [RULE_11] Control bit 1 enables test mode.
// [RULE_12] Control bit 0 disables checking; both reset zero.
// [RULE_13] Registers accessible without privilege.
// [RULE_14] Software writes each register before reading.
// [RULE_15] Unwritten register may report single or double error.
// [RULE_16] Global zero always reads zero.
// [RULE_17] In registers map to 24..31.
// [RULE_18] Outs 8..15, locals 16..23, globals 0..7.
// [RULE_19] Trap saves PC, nPC into locals 1,2.
// [RULE_20] Hit needs masked match and enabled type.
// [RULE_21] Reserved bits read zero, ignore writes.
module rfw_regfile
   import rfw_pkg::*;
#(
   parameter int WIN = NWIN
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire rfw_pkg::rfw_asr_req_t asr_req,
   output logic [31:0] asr_rdata,
   input wire rfw_pkg::rfw_watch_req_t watch_req,
   output logic debug_trap,
   output logic [3:0] watch_hit,
   input wire logic [2:0] cwp,
   input wire logic [4:0] rs1,
   input wire logic [4:0] rs2,
   output logic [31:0] rs1_data,
   output logic [31:0] rs2_data,
   output logic single_err,
   output logic double_err,
   input wire logic rd_we,
   input wire logic [4:0] rd,
   input wire logic [31:0] rd_data,
   input wire logic trap_save,
   input wire logic [31:0] trap_pc,
   input wire logic [31:0] trap_npc
);
   import rfw_pkg::*;

   localparam int DEPTH = 8 + 16 * WIN;
   localparam int AW = $clog2(DEPTH);

   logic [NUM_WATCH-1:0] addr_we;
   logic [NUM_WATCH-1:0] mask_we;
   logic [31:0] addr_rd [NUM_WATCH];
   logic [31:0] mask_rd [NUM_WATCH];
   logic [2:0] cnt_q;
   logic [6:0] tcb_q;
   logic test_q;
   logic dis_q;
   logic prot_we;
   logic [31:0] asr_rdata_d;
   logic [AW-1:0] ra_idx;
   logic [AW-1:0] rb_idx;
   logic [AW-1:0] w_idx;
   logic [38:0] ra_word;
   logic [38:0] rb_word;
   logic [38:0] w_word;
   logic w_en;
   logic [4:0] w_reg;
   logic [31:0] w_val;
   logic trap_second_q;
   logic [31:0] npc_hold_q;
   logic [2:0] save_cwp_q;
   logic ra_zero_q;
   logic rb_zero_q;
   logic [1:0] ra_syn;
   logic [1:0] rb_syn;
   logic [31:0] ra_fix;
   logic [31:0] rb_fix;
   logic corr_evt;

   ////////////////////////////////////////////////////////////////////////
   // Map a window-relative register to a physical slot. Ins of one window
   // overlap the outs of the next, so window w's ins equal window w+1's outs.
   function automatic logic [AW-1:0] phys(input logic [2:0] w,
      input logic [4:0] r);
      logic [AW-1:0] base;
      logic [2:0] wi;
      base = '0;
      wi = w;
      if (r < REG_OUT_BASE) begin // RULE_18
         phys = AW'(r);
      end else if (r < REG_LOCAL_BASE) begin // RULE_18
         phys = AW'(8 + 16 * int'(w) + int'(r - REG_OUT_BASE));
      end else if (r < REG_IN_BASE) begin // RULE_18
         phys = AW'(16 + 16 * int'(w) + int'(r - REG_LOCAL_BASE));
      end else begin
         // The last window wraps round to the outs of the first.
         wi = 3'((int'(w) + 1) % WIN);
         base = AW'(8 + 16 * int'(wi));
         phys = AW'(int'(base) + int'(r - REG_IN_BASE)); // RULE_17
      end
   endfunction : phys

   // Syndrome code of data bit i: the i-th number from 3 up that is not a
   // power of two, so a data bit never aliases a single checkbit.
   function automatic logic [5:0] dcode(input int i);
      int n;
      n = i + 3;
      for (int b = 2; b < 6; b++) begin
         if (n >= (1 << b)) begin
            n++;
         end
      end
      return 6'(n);
   endfunction : dcode

   // Seven checkbits: six code parities plus one that makes the whole
   // stored word even, which tells a single flip from a double one.
   function automatic logic [CB_W-1:0] checkbits(input logic [31:0] d);
      logic [CB_W-1:0] c;
      c = '0;
      for (int i = 0; i < 32; i++) begin
         if (d[i]) begin
            c[5:0] = c[5:0] ^ dcode(i);
         end
      end
      c[6] = ^d ^ (^c[5:0]);
      return c;
   endfunction : checkbits

   // Decode a stored word: syndrome class and a single-bit corrected value.
   function automatic logic [33:0] decode(input logic [38:0] word);
      logic [CB_W-1:0] syn;
      logic [31:0] d;
      logic [1:0] cls;
      syn = checkbits(word[31:0]) ^ word[38:32];
      d = word[31:0];
      cls = 2'h0;
      // Odd word parity means one flip, repaired here if it hit data;
      // even parity with a code left over means two.
      if (^word) begin
         cls = 2'h1;
         for (int i = 0; i < 32; i++) begin
            if (dcode(i) == syn[5:0]) begin
               d[i] = ~d[i];
            end
         end
      end else if (syn[5:0] != 6'h00) begin
         cls = 2'h2;
      end
      return {cls, d};
   endfunction : decode

   ////////////////////////////////////////////////////////////////////////
   // Ancillary write decode; no privilege check is made.
   always_comb begin
      addr_we = '0;
      mask_we = '0;
      prot_we = 1'b0;
      if (asr_req.wr && asr_req.num == ASR_PROT_CTRL) begin // RULE_13
         prot_we = 1'b1; // RULE_08
      end else if (asr_req.wr && asr_req.num >= ASR_WATCH_BASE) begin
         if (asr_req.num[0]) begin
            mask_we[asr_req.num[2:1]] = 1'b1; // RULE_02
         end else begin
            addr_we[asr_req.num[2:1]] = 1'b1; // RULE_01
         end
      end
   end

   // Four identical watchpoints.
   for (genvar g = 0; g < NUM_WATCH; g++) begin : g_watch
      rfw_watch_unit u_watch (
         .clk(clk),
         .rst_n(rst_n),
         .addr_we(addr_we[g]),
         .mask_we(mask_we[g]),
         .wdata(asr_req.wdata),
         .acc(watch_req),
         .addr_rd(addr_rd[g]),
         .mask_rd(mask_rd[g]),
         .hit(watch_hit[g])
      );
   end

   // Any hit raises the debug trap request to the pipeline.
   assign debug_trap = |watch_hit; // RULE_20

   ////////////////////////////////////////////////////////////////////////
   // Control fields written by software. Reserved bits have no flops, so
   // writes to them are lost.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tcb_q <= TCB_RESET;
         test_q <= 1'b0; // RULE_12
         dis_q <= 1'b0;
      end else if (prot_we) begin
         tcb_q <= asr_req.wdata[TCB_MSB:TCB_LSB];
         test_q <= asr_req.wdata[TEST_BIT]; // RULE_11
         dis_q <= asr_req.wdata[DISABLE_BIT]; // RULE_12
      end
   end

   // Correction counter: a correction in the write cycle beats the software
   // value so the event is not lost.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= CNT_RESET;
      end else if (corr_evt) begin
         if (cnt_q != 3'h7) begin
            cnt_q <= cnt_q + 3'h1; // RULE_09
         end
      end else if (prot_we) begin
         cnt_q <= asr_req.wdata[CNT_MSB:CNT_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped numbers and reserved bits return zero.
   always_comb begin
      asr_rdata_d = '0;
      if (asr_req.num == ASR_PROT_CTRL) begin
         asr_rdata_d = {20'h00000, cnt_q, tcb_q, test_q, dis_q}; // RULE_21
      end else if (asr_req.num >= ASR_WATCH_BASE) begin
         if (asr_req.num[0]) begin
            asr_rdata_d = mask_rd[asr_req.num[2:1]];
         end else begin
            asr_rdata_d = addr_rd[asr_req.num[2:1]];
         end
      end
   end

   // Read data is returned one cycle after the request.
   // It then holds, so a stalled pipeline may take it late.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         asr_rdata <= '0;
      end else if (asr_req.rd) begin
         asr_rdata <= asr_rdata_d; // RULE_13
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // A trap takes two write cycles: PC into local 1, then nPC into local 2,
   // both in the window current when the trap was taken.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trap_second_q <= 1'b0;
         npc_hold_q <= '0;
         save_cwp_q <= '0;
      end else begin
         trap_second_q <= trap_save;
         if (trap_save) begin
            npc_hold_q <= trap_npc;
            save_cwp_q <= cwp;
         end
      end
   end

   // Trap saves take the write port ahead of normal results.
   always_comb begin
      w_en = rd_we;
      w_reg = rd;
      w_val = rd_data;
      w_idx = phys(cwp, rd);
      if (trap_save) begin
         w_en = 1'b1;
         w_reg = REG_LOCAL1;
         w_val = trap_pc; // RULE_19
         w_idx = phys(cwp, REG_LOCAL1);
      end else if (trap_second_q) begin
         w_en = 1'b1;
         w_reg = REG_LOCAL2;
         w_val = npc_hold_q; // RULE_19
         w_idx = phys(save_cwp_q, REG_LOCAL2);
      end
   end

   // Test mode flips the chosen checkbits to inject errors.
   assign w_word = {checkbits(w_val) ^ (test_q ? tcb_q : 7'h00), // RULE_10
      w_val};

   // Both read ports follow the current window.
   assign ra_idx = phys(cwp, rs1);
   assign rb_idx = phys(cwp, rs2);

   // Writes aimed at global zero never reach the store.
   rfw_win_store #(
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_store (
      .clk(clk),
      .we(w_en && w_reg != 5'h00), // RULE_16
      .waddr(w_idx),
      .wdata(w_word),
      .raddr_a(ra_idx),
      .raddr_b(rb_idx),
      .rdata_a(ra_word),
      .rdata_b(rb_word)
   );

   // Remember zero-register reads to force zero at the output.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ra_zero_q <= 1'b1;
         rb_zero_q <= 1'b1;
      end else begin
         ra_zero_q <= (rs1 == 5'h00);
         rb_zero_q <= (rs2 == 5'h00);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Check and correct. Unwritten slots hold garbage checkbits, which the
   // decoder flags as single or double error depending on the pattern.
   assign {ra_syn, ra_fix} = decode(ra_word); // RULE_15
   assign {rb_syn, rb_fix} = decode(rb_word);

   // Read values and error flags; checking off passes raw data through.
   always_comb begin
      rs1_data = ra_zero_q ? 32'h00000000 // RULE_16
         : (dis_q ? ra_word[31:0] : ra_fix);
      rs2_data = rb_zero_q ? 32'h00000000
         : (dis_q ? rb_word[31:0] : rb_fix);
      single_err = !dis_q && ((!ra_zero_q && ra_syn == 2'h1)
         || (!rb_zero_q && rb_syn == 2'h1));
      double_err = !dis_q && ((!ra_zero_q && ra_syn == 2'h2)
         || (!rb_zero_q && rb_syn == 2'h2));
   end

   // Any cycle with a corrected operand on either port counts as one correction event.
   assign corr_evt = single_err; // RULE_09

endmodule : rfw_regfile

// ---- verification/rfw_regfile_chk.sv ----
// Checker for the register file block, watching only the top module's ports.
// Assumes the single core clock and the asynchronous active-low reset.
`timescale 1ns/1ps
module rfw_regfile_chk
   import rfw_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire rfw_pkg::rfw_asr_req_t asr_req,
   input wire logic [31:0] asr_rdata,
   input wire rfw_pkg::rfw_watch_req_t watch_req,
   input wire logic debug_trap,
   input wire logic [3:0] watch_hit,
   input wire logic [4:0] rs1,
   input wire logic [4:0] rs2,
   input wire logic [31:0] rs1_data,
   input wire logic single_err,
   input wire logic double_err
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // Numbers that hold a register; everything else must read back as zero.
   logic mapped;
   assign mapped = (asr_req.num == ASR_PROT_CTRL) || (asr_req.num >= ASR_WATCH_BASE);

   ////////////////////////////////////////////////////////////////////////////////
   a_unmapped_read_zero: assert property (asr_req.rd && !mapped |=> asr_rdata == 32'h00000000)
      else $error("unmapped number did not read zero");
   a_ctrl_reserved_zero: assert property (asr_req.rd && asr_req.num == ASR_PROT_CTRL
      |=> asr_rdata[31:12] == 20'h00000) else $error("control reserved bits not zero");
   a_waddr_bit_one: assert property (asr_req.rd && asr_req.num >= ASR_WATCH_BASE
      && !asr_req.num[0] |=> !asr_rdata[1]) else $error("watch address bit 1 not zero");
   a_mask_write_read: assert property (asr_req.wr && asr_req.num >= ASR_WATCH_BASE
      && asr_req.num[0] ##1 !asr_req.wr ##1 asr_req.rd && asr_req.num == $past(asr_req.num, 2)
      |=> asr_rdata == $past(asr_req.wdata, 3)) else $error("mask did not read back");
   a_ctrl_write_read: assert property (asr_req.wr && asr_req.num == ASR_PROT_CTRL
      ##1 !asr_req.wr ##1 asr_req.rd && asr_req.num == ASR_PROT_CTRL
      |=> asr_rdata[8:0] == $past(asr_req.wdata[8:0], 3)) else $error("control low bits lost");
   a_hit_needs_access: assert property (!(watch_req.fetch || watch_req.load || watch_req.store)
      |-> watch_hit == 4'h0) else $error("hit without an access");
   a_trap_from_hits: assert property (debug_trap == (|watch_hit))
      else $error("debug trap differs from hits");
   a_zero_reg_data: assert property (rs1 == 5'h00 |=> rs1_data == 32'h00000000)
      else $error("global zero read nonzero");
   a_zero_reg_clean: assert property (rs1 == 5'h00 && rs2 == 5'h00
      |=> !single_err && !double_err) else $error("error flagged on global zero");
endmodule : rfw_regfile_chk

bind rfw_regfile rfw_regfile_chk chk (.clk(clk), .rst_n(rst_n), .asr_req(asr_req),
   .asr_rdata(asr_rdata), .watch_req(watch_req), .debug_trap(debug_trap),
   .watch_hit(watch_hit), .rs1(rs1), .rs2(rs2), .rs1_data(rs1_data),
   .single_err(single_err), .double_err(double_err));

// ---- verification/rfw_iu_model.sv ----
// Pipeline model: issues ancillary, working-register, trap and watch accesses.
// Assumes one caller at a time; drives land just after a rising edge.
`timescale 1ns/1ps
module rfw_iu_model
   import rfw_pkg::*;
(
   input wire logic clk,
   output rfw_pkg::rfw_asr_req_t asr_req,
   input wire logic [31:0] asr_rdata,
   output rfw_pkg::rfw_watch_req_t watch_req,
   input wire logic [3:0] watch_hit,
   output logic [2:0] cwp,
   output logic [4:0] rs1,
   output logic [4:0] rs2,
   input wire logic [31:0] rs1_data,
   input wire logic single_err,
   input wire logic double_err,
   output logic rd_we,
   output logic [4:0] rd,
   output logic [31:0] rd_data,
   output logic trap_save,
   output logic [31:0] trap_pc,
   output logic [31:0] trap_npc
);
   // Quiet pipeline at time zero.
   initial begin
      asr_req = '0;
      watch_req = '0;
      cwp = 3'h0;
      rs1 = 5'h00;
      rs2 = 5'h00;
      rd_we = 1'b0;
      rd = 5'h00;
      rd_data = 32'h00000000;
      trap_save = 1'b0;
      trap_pc = 32'h00000000;
      trap_npc = 32'h00000000;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One-cycle ancillary strobe; released fields flip so stale data never looks valid.
   task automatic asr(input logic w, input logic [4:0] n, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      asr_req <= '{w, ~w, n, d};
      @(posedge clk);
      asr_req <= '{1'b0, 1'b0, ~n, ~d};
      #1 q = asr_rdata;
   endtask : asr

   // Every slot but global zero is written before any read of it; slot 0 is read while parked but never written.
   task automatic rf_wr(input logic [2:0] w, input logic [4:0] r, input logic [31:0] d);
      @(posedge clk);
      cwp <= w;
      rd_we <= 1'b1;
      rd <= r;
      rd_data <= d;
      @(posedge clk);
      rd_we <= 1'b0;
      rd_data <= ~d;
   endtask : rf_wr

   // Data and flags settle a cycle later; parking on global zero counts each error once.
   task automatic rf_rd(input logic [2:0] w, input logic [4:0] r, output logic [31:0] q,
                        output logic [1:0] e);
      @(posedge clk);
      cwp <= w;
      rs1 <= r;
      rs2 <= r;
      @(posedge clk);
      #1 q = rs1_data;
      e = {single_err, double_err};
      rs1 <= 5'h00;
      rs2 <= 5'h00;
   endtask : rf_rd

   // Saved values are inverted only after both save edges have passed.
   task automatic trap(input logic [2:0] w, input logic [31:0] pc, input logic [31:0] npc);
      @(posedge clk);
      cwp <= w;
      trap_save <= 1'b1;
      trap_pc <= pc;
      trap_npc <= npc;
      @(posedge clk);
      trap_save <= 1'b0;
      @(posedge clk);
      trap_pc <= ~pc;
      trap_npc <= ~npc;
   endtask : trap

   // Hits are combinational, so they are sampled in the same cycle.
   task automatic acc(input logic [2:0] t, input logic [31:0] a, output logic [3:0] h);
      @(posedge clk);
      watch_req <= '{t[0], t[1], t[2], a};
      #1 h = watch_hit;
   endtask : acc
endmodule : rfw_iu_model

// ---- verification/test_rfw_regfile.sv ----
// Self-checking bench for the register file, its protection control and watchpoints.
// Assumes the pipeline model drives every input except clock and reset.
`timescale 1ns/1ps
module test_rfw_regfile;
   import rfw_pkg::*;
   logic clk;
   logic rst_n;
   rfw_asr_req_t asr_req;
   rfw_watch_req_t watch_req;
   logic [31:0] asr_rdata, rs1_data, rs2_data, rd_data, trap_pc, trap_npc, q, a;
   logic [31:0] wa [4];
   logic [31:0] wm [4];
   logic [31:0] rv [8];
   logic [4:0] rs1, rs2, rd;
   logic [3:0] watch_hit, h;
   logic [2:0] cwp, t;
   logic [1:0] e;
   logic debug_trap, single_err, double_err, rd_we, trap_save;
   int n_errors = 0;
   int samples_checked = 0;
   int seed = 67;
   int cycles = 0;

   rfw_regfile uut (.clk(clk), .rst_n(rst_n), .asr_req(asr_req), .asr_rdata(asr_rdata),
      .watch_req(watch_req), .debug_trap(debug_trap), .watch_hit(watch_hit), .cwp(cwp),
      .rs1(rs1), .rs2(rs2), .rs1_data(rs1_data), .rs2_data(rs2_data), .single_err(single_err),
      .double_err(double_err), .rd_we(rd_we), .rd(rd), .rd_data(rd_data),
      .trap_save(trap_save), .trap_pc(trap_pc), .trap_npc(trap_npc));
   rfw_iu_model iu (.clk(clk), .asr_req(asr_req), .asr_rdata(asr_rdata),
      .watch_req(watch_req), .watch_hit(watch_hit), .cwp(cwp), .rs1(rs1), .rs2(rs2),
      .rs1_data(rs1_data), .single_err(single_err), .double_err(double_err), .rd_we(rd_we),
      .rd(rd), .rd_data(rd_data), .trap_save(trap_save), .trap_pc(trap_pc),
      .trap_npc(trap_npc));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   // Bits 1:0 are enables, not address.
   function automatic logic [3:0] exp_hit(input logic [2:0] t, input logic [31:0] a);
      for (int i = 0; i < 4; i++) begin
         exp_hit[i] = ~|((a ^ wa[i]) & wm[i] & 32'hFFFFFFFC) &
            ((t[0] & wa[i][0]) | (t[1] & wm[i][1]) | (t[2] & wm[i][0]));
      end
   endfunction : exp_hit

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // A hang ends the run long after a clean one would.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         end_of_test();
      end
   end

   initial begin
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values, then writes to an unmapped number and reserved bits.
      for (int n = 16; n < 32; n++) begin
         iu.asr(1'b0, n[4:0], 32'h00000000, q);
         check("reset value", q, 32'h00000000);
      end
      iu.asr(1'b1, 5'h05, 32'hFFFFFFFF, q);
      iu.asr(1'b0, 5'h05, 32'h00000000, q);
      check("unmapped", q, 32'h00000000);
      iu.asr(1'b1, ASR_PROT_CTRL, 32'hFFFFFFFC, q);
      iu.asr(1'b0, ASR_PROT_CTRL, 32'h00000000, q);
      check("control", q, 32'h00000FFC);
      // Random watchpoints, with fetch, load and store each forced on somewhere.
      for (int i = 0; i < 4; i++) begin
         wa[i] = $random(seed);
         wm[i] = $random(seed) | 32'hFFF00000;
         wa[i][0] = wa[i][0] | (i == 0);
         wm[i][1] = wm[i][1] | (i == 1);
         wm[i][0] = wm[i][0] | (i == 2);
         iu.asr(1'b1, ASR_WATCH_BASE + 5'(2 * i), wa[i], q);
         iu.asr(1'b0, ASR_WATCH_BASE + 5'(2 * i), 32'h00000000, q);
         wa[i][1] = 1'b0;
         check("watch address", q, wa[i]);
         iu.asr(1'b1, ASR_WATCH_BASE + 5'(2 * i + 1), wm[i], q);
         iu.asr(1'b0, ASR_WATCH_BASE + 5'(2 * i + 1), 32'h00000000, q);
         check("watch mask", q, wm[i]);
      end
      // Accesses near a watched address; every third flips one address bit from bit 2 up.
      for (int k = 0; k < 300; k++) begin
         t = 3'($random(seed));
         a = wa[k % 4] ^ ($random(seed) & ~wm[k % 4]) ^ ((k % 3 == 0) << (2 + k % 30));
         iu.acc(t, a, h);
         check("watch hit", 32'(h), 32'(exp_hit(t, a)));
      end
      // Global zero ignores writes; outs of window w+1 are the ins of window w.
      iu.rf_wr(3'h0, 5'h00, 32'hFFFFFFFF);
      iu.rf_rd(3'h0, 5'h00, q, e);
      check("global zero", q, 32'h00000000);
      for (int w = 0; w < 8; w++) begin
         rv[w] = $random(seed);
         iu.rf_wr(3'(w + 1), REG_OUT_BASE + 5'(w), rv[w]);
         iu.rf_wr(3'(w), REG_LOCAL_BASE, ~rv[w]);
      end
      iu.rf_wr(3'h5, 5'h07, rv[0]);
      for (int w = 0; w < 8; w++) begin
         iu.rf_rd(3'(w), REG_IN_BASE + 5'(w), q, e);
         check("in register", q, rv[w]);
         check("second port", rs2_data, rv[w]);
         iu.rf_rd(3'(w), REG_LOCAL_BASE, q, e);
         check("local register", q, ~rv[w]);
         iu.rf_rd(3'(w), 5'h07, q, e);
         check("global register", q, rv[0]);
         check("clean flags", 32'(e), 32'h00000000);
      end
      iu.trap(3'h2, rv[3], rv[4]);
      iu.rf_rd(3'h2, REG_LOCAL1, q, e);
      check("saved pc", q, rv[3]);
      iu.rf_rd(3'h2, REG_LOCAL2, q, e);
      check("saved npc", q, rv[4]);
      // One flipped checkbit in eight locals: eight corrections saturate the counter.
      iu.asr(1'b1, ASR_PROT_CTRL, 32'h00000006, q);
      for (int r = 0; r < 8; r++) begin
         iu.rf_wr(3'h3, REG_LOCAL_BASE + 5'(r), rv[r]);
      end
      iu.asr(1'b1, ASR_PROT_CTRL, 32'h00000000, q);
      for (int r = 0; r < 8; r++) begin
         iu.rf_rd(3'h3, REG_LOCAL_BASE + 5'(r), q, e);
         check("corrected data", q, rv[r]);
         check("single flag", 32'(e), 32'h00000002);
      end
      iu.asr(1'b0, ASR_PROT_CTRL, 32'h00000000, q);
      check("counter", q, 32'h00000E00);
      // Two flipped checkbits are detected; with checking disabled nothing is flagged.
      iu.asr(1'b1, ASR_PROT_CTRL, 32'h0000000E, q);
      iu.rf_wr(3'h3, 5'h14, rv[5]);
      iu.asr(1'b1, ASR_PROT_CTRL, 32'h00000007, q);
      iu.rf_wr(3'h3, 5'h15, rv[6]);
      iu.rf_rd(3'h3, 5'h15, q, e);
      check("disabled flags", 32'(e), 32'h00000000);
      iu.asr(1'b1, ASR_PROT_CTRL, 32'h00000000, q);
      iu.rf_rd(3'h3, 5'h14, q, e);
      check("double flag", 32'(e), 32'h00000001);
      end_of_test();
   end
endmodule : test_rfw_regfile
